/* File: cms_map.svh */
/*
  register offsets, field positions, reset values and timing figures
  of the charger mode sequencer.
  assumes inclusion by bare name from every file that needs them.
*/
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH

// ****************************************
// register map
// ****************************************
`define CMS_REG_CTRL       12'h000
`define CMS_REG_CHG_CUR    12'h004
`define CMS_REG_CHG_VOLT   12'h008
`define CMS_REG_STATUS     12'h00C
`define CMS_CTRL_ILE       1
`define CMS_CTRL_LDO       2
`define CMS_CTRL_LEARN     5
`define CMS_CTRL_AUDIO     10
`define CMS_CTRL_RST       16'h0004
`define CMS_CTRL_MASK      16'h0426

// ****************************************
// pin vector positions
// ****************************************
`define CMS_PIN_ADP        0
`define CMS_PIN_INOVR      1
`define CMS_PIN_DIS256     2
`define CMS_PIN_BATLOW     3
`define CMS_PIN_LIGHT      4
`define CMS_PIN_BOOTLOW    5
`define CMS_PIN_ZCROSS     6
`define CMS_PIN_CELL       7

// ****************************************
// timing and scaling
// ****************************************
`define CMS_CLK_MHZ        200
`define CMS_SS_STEP_US     24
`define CMS_CELL_LATCH_MS  100
`define CMS_RESTART_US     200
`define CMS_AUDIO_KHZ      40
`define CMS_CUR_LSB_MA     64
`define CMS_SS_START_MA    128
`define CMS_PRECHG_MAX_MA  384
`define CMS_RAMP_LSB_MV    10
`define CMS_RAMP_START_MV  200
`define CMS_BOOT_CYC       2
`define CMS_DEAD_CYC       2
`define CMS_PERIOD_CYC     250

`endif

/* File: cms_pkg.sv */
/*
  types of the charger mode sequencer.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package cms_pkg;
  typedef enum logic [3:0] {
    CMS_G_OFF  = 4'b0001,
    CMS_G_HS   = 4'b0010,
    CMS_G_DEAD = 4'b0100,
    CMS_G_LS   = 4'b1000
  } cms_gate_state_t;
  typedef logic [6:0] cms_cur_t;
endpackage
`default_nettype wire

/* File: cms_gate_if.sv */
/*
  gate request and gate state between sequencer and gate driver.
  assumes both ends share one clock.
*/
`default_nettype none
interface cms_gate_if;
  logic hs_req;
  logic ls_req;
  logic hs_on;
  logic ls_on;
  modport ctrl (output hs_req, output ls_req, input hs_on, input ls_on);
  modport drv  (input hs_req, input ls_req, output hs_on, output ls_on);
endinterface
`default_nettype wire

/* File: cms_gate_driver.sv */
/*
  break-before-make gate driver for the two converter switches.
  assumes requests come from logic on the same clock.
*/
`include "cms_map.svh"
`default_nettype none
module cms_gate_driver #(
  parameter int unsigned DEAD_CYC = `CMS_DEAD_CYC
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  cms_gate_if.drv   gate
);
  cms_pkg::cms_gate_state_t state_q;
  cms_pkg::cms_gate_state_t state_d;
  logic [3:0]               dead_q;
  logic                     hs_q;
  logic                     ls_q;
  wire                      dead_done = (dead_q == 4'(DEAD_CYC - 1));

  // ****************************************
  // state sequencing
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cms_pkg::CMS_G_OFF: begin
        if (gate.hs_req) state_d = cms_pkg::CMS_G_HS;
        else if (gate.ls_req) state_d = cms_pkg::CMS_G_LS;
      end
      cms_pkg::CMS_G_HS: begin
        if (!gate.hs_req) state_d = cms_pkg::CMS_G_DEAD;
      end
      cms_pkg::CMS_G_LS: begin
        if (!gate.ls_req || gate.hs_req) state_d = cms_pkg::CMS_G_DEAD;
      end
      cms_pkg::CMS_G_DEAD: begin
        if (dead_done) state_d = cms_pkg::CMS_G_OFF;
      end
      default: state_d = cms_pkg::CMS_G_OFF;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= cms_pkg::CMS_G_OFF;
      dead_q  <= 4'h0;
      hs_q    <= 1'b0;
      ls_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      dead_q  <= (state_q == cms_pkg::CMS_G_DEAD) ? dead_q + 4'h1 : 4'h0;
      hs_q    <= (state_d == cms_pkg::CMS_G_HS);
      ls_q    <= (state_d == cms_pkg::CMS_G_LS);
    end
  end

  assign gate.hs_on = hs_q;
  assign gate.ls_on = ls_q;

  property p_no_overlap;
    @(posedge clock_i) disable iff (srst_i)
    $fell(hs_q) |-> !ls_q [*2];
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("low side on within dead time");
endmodule
`default_nettype wire

/* File: cms_charger_mode_sequencer.sv */
/*
  mode and sequencing logic of a buck charger: converter start, soft
  start staircase, cell latch, battery switch modes, switch timing,
  pulse-frequency mode and calibration mode, with an APB slave.
  assumes comparator pins are asynchronous and loop demands are on clock_i.
*/
`include "cms_map.svh"
`default_nettype none
module cms_charger_mode_sequencer #(
  parameter int unsigned PERIOD_CYC     = `CMS_PERIOD_CYC,
  parameter int unsigned SS_STEP_CYC    = `CMS_SS_STEP_US * `CMS_CLK_MHZ,
  parameter int unsigned CELL_LATCH_CYC =
    `CMS_CELL_LATCH_MS * 1000 * `CMS_CLK_MHZ,
  parameter int unsigned RESTART_CYC    = `CMS_RESTART_US * `CMS_CLK_MHZ,
  parameter int unsigned AUDIO_CYC      =
    (`CMS_CLK_MHZ * 1000) / `CMS_AUDIO_KHZ
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        adapter_present_i,
  input  wire logic        input_over_limit_i,
  input  wire logic        discharge_over_256_i,
  input  wire logic        battery_below_minsys_i,
  input  wire logic        light_load_i,
  input  wire logic        bootstrap_low_i,
  input  wire logic        input_sense_low_i,
  input  wire logic        cell_pin_i,
  input  wire logic [7:0]  loop_input_current_i,
  input  wire logic [7:0]  loop_charge_current_i,
  input  wire logic [7:0]  loop_charge_voltage_i,
  input  wire logic [7:0]  loop_minsys_voltage_i,
  output logic             adapter_switch_drive_o,
  output logic             battery_switch_full_o,
  output logic             battery_switch_linear_o,
  output logic             high_side_switch_o,
  output logic             low_side_switch_o,
  output logic      [6:0]  charge_current_target_o,
  output logic      [10:0] charge_voltage_o,
  output logic             cell_3s_o,
  output logic             pfm_mode_o
);
  localparam int unsigned CW = 25;
  localparam int unsigned PW = $clog2(PERIOD_CYC);
  localparam cms_pkg::cms_cur_t SS_START =
    7'(`CMS_SS_START_MA / `CMS_CUR_LSB_MA);
  localparam cms_pkg::cms_cur_t PRE_MAX =
    7'(`CMS_PRECHG_MAX_MA / `CMS_CUR_LSB_MA - 1);
  localparam logic [9:0] RAMP_START =
    10'(`CMS_RAMP_START_MV / `CMS_RAMP_LSB_MV);

  function automatic logic [7:0] max2(input logic [7:0] a,
                                      input logic [7:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  function automatic cms_pkg::cms_cur_t min2(input cms_pkg::cms_cur_t a,
                                             input cms_pkg::cms_cur_t b);
    min2 = (a < b) ? a : b;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [7:0] pin_meta_q;
  logic [7:0] pin_q;
  wire  [7:0] pin_raw = {cell_pin_i, input_sense_low_i, bootstrap_low_i,
                         light_load_i, battery_below_minsys_i,
                         discharge_over_256_i, input_over_limit_i,
                         adapter_present_i};
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_meta_q <= 8'h00;
      pin_q      <= 8'h00;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q      <= pin_meta_q;
    end
  end
  wire adp      = pin_q[`CMS_PIN_ADP];
  wire in_over  = pin_q[`CMS_PIN_INOVR];
  wire dis_over = pin_q[`CMS_PIN_DIS256];
  wire bat_low  = pin_q[`CMS_PIN_BATLOW];
  wire light    = pin_q[`CMS_PIN_LIGHT];
  wire boot_low = pin_q[`CMS_PIN_BOOTLOW];
  wire sense_lo = pin_q[`CMS_PIN_ZCROSS];
  wire cell_hi  = pin_q[`CMS_PIN_CELL];

  // ****************************************
  // register file
  // ****************************************
  logic [15:0]       ctrl_q;
  cms_pkg::cms_cur_t cur_q;
  logic [10:0]       volt_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;
  logic              locked_q;
  logic              cell_3s_q;
  logic              conv_q;
  logic              bat_lin_q;
  logic              pfm_q;
  logic              nosoft_q;
  cms_pkg::cms_cur_t target_q;

  wire access    = psel_i & penable_i & ~pready_q;
  wire hit_ctrl  = (paddr_i == `CMS_REG_CTRL);
  wire hit_cur   = (paddr_i == `CMS_REG_CHG_CUR);
  wire hit_volt  = (paddr_i == `CMS_REG_CHG_VOLT);
  wire hit_stat  = (paddr_i == `CMS_REG_STATUS);
  wire mapped    = hit_ctrl | hit_cur | hit_volt | hit_stat;
  wire wr        = psel_i & penable_i & pready_q & pwrite_i;
  wire cell_clr  = locked_q & ~cell_hi;
  wire [31:0] status_w = {9'h000, target_q, 10'h000, nosoft_q, pfm_q,
                          bat_lin_q, conv_q, cell_3s_q, locked_q};
  wire [31:0] rdata_w  =
    hit_ctrl ? {16'h0000, ctrl_q} :
    hit_cur  ? {25'h0000000, cur_q} :
    hit_volt ? {21'h000000, volt_q} :
    hit_stat ? status_w : 32'h00000000;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access & ~mapped;
      if (access & ~pwrite_i) prdata_q <= rdata_w;
    end
  end

  // pin-forced exit of calibration wins over a same-cycle write
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_q <= `CMS_CTRL_RST;
      cur_q  <= 7'h00;
      volt_q <= 11'h000;
    end else begin
      if (wr & hit_ctrl) ctrl_q <= pwdata_i[15:0] & `CMS_CTRL_MASK;
      if (wr & hit_cur)  cur_q  <= pwdata_i[6:0];
      if (wr & hit_volt) volt_q <= pwdata_i[10:0];
      if (cell_clr) begin
        ctrl_q[`CMS_CTRL_LEARN] <= 1'b0;
        ctrl_q[`CMS_CTRL_ILE]   <= 1'b0;
        cur_q                   <= 7'h00;
        volt_q                  <= 11'h000;
      end
    end
  end

  // ****************************************
  // power path and converter enable
  // ****************************************
  logic          adp_sw_q;
  logic          bat_full_q;
  logic          learn_was_q;
  logic [CW-1:0] restart_q;
  logic [CW-1:0] cell_cnt_q;
  wire ldo_bit   = ctrl_q[`CMS_CTRL_LDO];
  wire learn_act = ctrl_q[`CMS_CTRL_LEARN] & adp;
  wire learn_exit = learn_was_q & ~learn_act & adp;
  wire bat_full_d = ~adp | learn_act | dis_over | ~ldo_bit | ~bat_low;
  wire conv_d    = adp_sw_q & ~learn_act & ~learn_exit & (restart_q == '0);
  wire start_ev  = conv_d & ~conv_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      adp_sw_q    <= 1'b0;
      bat_full_q  <= 1'b1;
      bat_lin_q   <= 1'b0;
      learn_was_q <= 1'b0;
      restart_q   <= '0;
      conv_q      <= 1'b0;
      nosoft_q    <= 1'b0;
    end else begin
      adp_sw_q    <= adp;
      bat_full_q  <= bat_full_d;
      bat_lin_q   <= ~bat_full_d;
      learn_was_q <= learn_act;
      conv_q      <= conv_d;
      if (learn_exit) restart_q <= CW'(RESTART_CYC - 1);
      else if (restart_q != '0) restart_q <= restart_q - 1'b1;
      if (learn_exit) nosoft_q <= 1'b1;
      else if (start_ev) nosoft_q <= 1'b0;
    end
  end

  // ****************************************
  // cell-count latch
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cell_cnt_q <= '0;
      locked_q   <= 1'b0;
      cell_3s_q  <= 1'b0;
    end else begin
      if (conv_q && !locked_q) cell_cnt_q <= cell_cnt_q + 1'b1;
      if (cell_cnt_q == CW'(CELL_LATCH_CYC - 1)) locked_q <= 1'b1;
      if (!locked_q) cell_3s_q <= cell_hi;
    end
  end

  // ****************************************
  // current target staircase
  // ****************************************
  logic [CW-1:0] ss_cnt_q;
  wire ss_tick  = (ss_cnt_q == CW'(SS_STEP_CYC - 1));
  wire throttle = ctrl_q[`CMS_CTRL_ILE] & in_over;
  wire cms_pkg::cms_cur_t lim_w = bat_lin_q ? min2(cur_q, PRE_MAX) : cur_q;
  cms_pkg::cms_cur_t target_d;
  always_comb begin
    target_d = target_q;
    if (start_ev) target_d = nosoft_q ? lim_w : min2(SS_START, lim_w);
    else if (!conv_q) target_d = 7'h00;
    else if (target_q > lim_w) target_d = lim_w;
    else if (ss_tick && throttle && target_q != 7'h00)
      target_d = target_q - 7'h01;
    else if (ss_tick && !throttle && target_q < lim_w)
      target_d = target_q + 7'h01;
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ss_cnt_q <= '0;
      target_q <= 7'h00;
    end else begin
      ss_cnt_q <= (!conv_q || start_ev || ss_tick) ? '0 : ss_cnt_q + 1'b1;
      target_q <= target_d;
    end
  end

  // ****************************************
  // switching cycle
  // ****************************************
  logic [PW-1:0] phase_q;
  logic          run_q;
  logic          force_q;
  logic          refresh_q;
  logic          lo_cut_q;
  logic [CW-1:0] audio_q;
  cms_gate_if    gif ();
  wire [7:0] demand = max2(max2(loop_input_current_i, loop_charge_current_i),
                           max2(loop_charge_voltage_i,
                                loop_minsys_voltage_i));
  wire [9:0] ramp_w  = RAMP_START + 10'(phase_q);
  wire last_ph  = (phase_q == PW'(PERIOD_CYC - 1));
  wire boot_win = refresh_q & (phase_q < PW'(`CMS_BOOT_CYC));
  wire audio_due = ctrl_q[`CMS_CTRL_AUDIO] & (audio_q == '0);
  wire pfm_d    = light & ((cur_q == 7'h00) | bat_lin_q);
  wire run_d    = ~pfm_q | ({2'b00, demand} > RAMP_START) | audio_due;
  wire hs_pulse = ({2'b00, demand} > ramp_w) | (force_q & phase_q == '0);
  assign gif.hs_req = conv_q & run_q & ~boot_win & ~last_ph & hs_pulse;
  assign gif.ls_req = conv_q & ~last_ph &
                      (boot_win | (run_q & ~hs_pulse & ~lo_cut_q));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      phase_q   <= '0;
      run_q     <= 1'b0;
      force_q   <= 1'b0;
      refresh_q <= 1'b0;
      lo_cut_q  <= 1'b0;
      audio_q   <= '0;
      pfm_q     <= 1'b0;
    end else begin
      pfm_q   <= pfm_d;
      phase_q <= (!conv_q || last_ph) ? '0 : phase_q + 1'b1;
      lo_cut_q <= ((last_ph || !conv_q) ? 1'b0 : lo_cut_q) | sense_lo;
      if (last_ph || start_ev) begin
        run_q     <= run_d;
        force_q   <= pfm_q & audio_due;
        refresh_q <= boot_low;
        audio_q   <= run_d ? CW'(AUDIO_CYC - 1) : audio_q;
      end else if (audio_q != '0) begin
        audio_q <= audio_q - 1'b1;
      end
    end
  end

  cms_gate_driver u_gate (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .gate    (gif)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign prdata_o                = prdata_q;
  assign pready_o                = pready_q;
  assign pslverr_o               = pslverr_q;
  assign adapter_switch_drive_o  = adp_sw_q;
  assign battery_switch_full_o   = bat_full_q;
  assign battery_switch_linear_o = bat_lin_q;
  assign high_side_switch_o      = gif.hs_on;
  assign low_side_switch_o       = gif.ls_on;
  assign charge_current_target_o = target_q;
  assign charge_voltage_o        = volt_q;
  assign cell_3s_o               = cell_3s_q;
  assign pfm_mode_o              = pfm_q;

  // ****************************************
  // checks
  // ****************************************
  property p_conv_after_adp;
    @(posedge clock_i) disable iff (srst_i) conv_q |-> $past(adp_sw_q);
  endproperty
  a_conv_after_adp: assert property (p_conv_after_adp)
    else $error("converter on without adapter switch");

  property p_ss_first;
    @(posedge clock_i) disable iff (srst_i)
    (start_ev && !nosoft_q) |=> target_q <= SS_START;
  endproperty
  a_ss_first: assert property (p_ss_first)
    else $error("soft start began above first step");

  property p_step_one;
    @(posedge clock_i) disable iff (srst_i)
    ($past(conv_q) && conv_q && target_q > $past(target_q))
      |-> target_q == $past(target_q) + 7'h01;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("staircase step not one increment");

  property p_no_overshoot;
    @(posedge clock_i) disable iff (srst_i)
    (conv_q && $stable(cur_q) && $stable(bat_lin_q)) |=> target_q <= cur_q;
  endproperty
  a_no_overshoot: assert property (p_no_overshoot)
    else $error("target above programmed current");

  property p_precharge;
    @(posedge clock_i) disable iff (srst_i)
    bat_lin_q [*2] |-> target_q <= PRE_MAX;
  endproperty
  a_precharge: assert property (p_precharge)
    else $error("precharge target not clamped");

  property p_learn;
    @(posedge clock_i) disable iff (srst_i)
    learn_act |=> ##1 (!conv_q && bat_full_q && adp_sw_q);
  endproperty
  a_learn: assert property (p_learn)
    else $error("calibration mode not honoured");

  property p_cell_clear;
    @(posedge clock_i) disable iff (srst_i)
    cell_clr |=> (!ctrl_q[`CMS_CTRL_LEARN] && cur_q == 7'h00 && volt_q == 11'h000);
  endproperty
  a_cell_clear: assert property (p_cell_clear)
    else $error("grounded cell pin did not clear settings");

  property p_cell_locked;
    @(posedge clock_i) disable iff (srst_i) locked_q |=> $stable(cell_3s_q);
  endproperty
  a_cell_locked: assert property (p_cell_locked)
    else $error("cell setting changed after latch");

  property p_discharge;
    @(posedge clock_i) disable iff (srst_i) dis_over |=> bat_full_q;
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("battery switch not full on at discharge");

  property p_lo_cut;
    @(posedge clock_i) disable iff (srst_i)
    (lo_cut_q && !boot_win) |-> !gif.ls_req;
  endproperty
  a_lo_cut: assert property (p_lo_cut)
    else $error("low side requested after sense low");
endmodule
`default_nettype wire

/* File: cms_power_stage_model.sv */
/*
  power stage model: inductor current and bootstrap charge.
  assumes gate outputs change on clock_i.
*/
`default_nettype none
module cms_power_stage_model (
  input  wire logic clock_i,
  input  wire logic high_side_i,
  input  wire logic low_side_i,
  output logic      bootstrap_low_o,
  output logic      sense_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // inductor and bootstrap
  // ****************************************
  int ind_q = 0;
  int run_q = 0;
  always @(posedge clock_i) begin
    if (high_side_i === 1'b1) ind_q <= ind_q + 2;
    else if (low_side_i === 1'b1 && ind_q > 0) ind_q <= ind_q - 1;
    run_q <= (high_side_i === 1'b1) ? run_q + 1 : 0;
  end
  // current reaches zero while the low side conducts
  assign sense_low_o = (low_side_i === 1'b1) && ind_q == 0;
  // a long high side run drains the bootstrap cap
  assign bootstrap_low_o = run_q > 30;
endmodule
`default_nettype wire

/* File: cms_charger_mode_sequencer_test.sv */
/*
  self-checking bench of the charger mode sequencer.
  assumes the design files and the power stage model come first.
*/
`default_nettype none
module cms_charger_mode_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hold = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, rd, lf = 32'hE29B;
  logic        adp = 0, ovr = 0, dis = 0, blo = 0, lgt = 0, cel = 1;
  logic        rdy, err, e, bst, zc, acd, bfl, bln, hs, ls, c3s, pfm;
  logic        hp = 0;
  logic [7:0]  lp [4] = '{default: 8'h00};
  logic [31:0] prd;
  logic [6:0]  tgt;
  logic [10:0] vlt;
  int          miscompares = 0, comparisons = 0, n, hsn = 0, q[$], x[$];
  cms_charger_mode_sequencer #(.PERIOD_CYC(40), .SS_STEP_CYC(8),
    .CELL_LATCH_CYC(50), .RESTART_CYC(10), .AUDIO_CYC(600))
  i_cms_charger_mode_sequencer (.clock_i(clk), .srst_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .adapter_present_i(adp), .input_over_limit_i(ovr),
    .discharge_over_256_i(dis), .battery_below_minsys_i(blo),
    .light_load_i(lgt), .bootstrap_low_i(bst), .input_sense_low_i(zc),
    .cell_pin_i(cel), .loop_input_current_i(lp[0]),
    .loop_charge_current_i(lp[1]), .loop_charge_voltage_i(lp[2]),
    .loop_minsys_voltage_i(lp[3]), .adapter_switch_drive_o(acd),
    .battery_switch_full_o(bfl), .battery_switch_linear_o(bln),
    .high_side_switch_o(hs), .low_side_switch_o(ls),
    .charge_current_target_o(tgt), .charge_voltage_o(vlt),
    .cell_3s_o(c3s), .pfm_mode_o(pfm));
  cms_power_stage_model i_cms_power_stage_model (.clock_i(clk),
    .high_side_i(hs), .low_side_i(ls), .bootstrap_low_o(bst),
    .sense_low_o(zc));
  // ****************************************
  // clock, stimulus, monitor
  // ****************************************
  always #2.5 clk = ~clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    lf <= nx(lf);
    for (int i = 0; i < 4; i++) lp[i] <= hold ? 8'h00 : lf[8*i +: 8];
  end
  always @(posedge clk) begin
    hp <= hs;
    if (hs === 1'b1 && hp !== 1'b1) hsn++;
    if ((hs & ls) === 1'b1) chk("both gates", 0, 1);
    if ((hs & ~acd) === 1'b1) chk("hs early", 0, 1);
    if (!rst && (q.size() == 0 || tgt !== q[$])) q.push_back(int'(tgt));
  end
  task automatic chk(input string nm, input logic [31:0] s, ex);
    comparisons++;
    if (s !== ex) begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", nm, ex, s);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic guard(input int c);
    if (n >= c) begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    guard(50);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    cyc(5);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", rd, 32'h0000_0004);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", e, 1);
    chk("cell 3s", c3s, 1);
    apb(1'b1, 12'h004, 32'h0000_0004);
    apb(1'b1, 12'h008, 32'h0000_0465);
    apb(1'b1, 12'h000, 32'h0);
    blo <= 1'b1;
    adp <= 1'b1;
    q.delete();
    for (n = 0; tgt !== 7'h04 && n < 500; n++) @(posedge clk);
    guard(500);
    cyc(40);
    x = '{0};
    for (int v = 2; v <= 4; v++) x.push_back(v);
    chk("steps", q.size(), x.size());
    foreach (x[i]) chk("step", q[i], x[i]);
    chk("full", {bfl, bln}, 2'b10);
    chk("volt", vlt, 11'h465);
    chk("hs runs", hsn > 0, 1);
    apb(1'b1, 12'h000, 32'h0000_0004);
    cyc(6);
    chk("linear", {bfl, bln}, 2'b01);
    dis <= 1'b1;
    cyc(6);
    chk("discharge", bfl, 1);
    dis <= 1'b0;
    blo <= 1'b0;
    cyc(6);
    chk("minsys", {bfl, bln}, 2'b10);
    apb(1'b1, 12'h000, 32'h0000_0006);
    ovr <= 1'b1;
    cyc(30);
    chk("throttle", tgt < 7'h04, 1);
    ovr <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0024);
    cyc(6);
    chk("learn", {tgt, bfl, acd, hs}, {7'h00, 3'b110});
    apb(1'b1, 12'h000, 32'h0000_0004);
    for (n = 0; tgt === 7'h00 && n < 100; n++) @(posedge clk);
    guard(100);
    chk("restart", tgt, 7'h04);
    apb(1'b0, 12'h00C, 32'h0);
    chk("status", rd, 32'h0004_0007);
    apb(1'b1, 12'h000, 32'h0000_0026);
    cel <= 1'b0;
    cyc(6);
    apb(1'b0, 12'h000, 32'h0);
    chk("pin clear", rd, 32'h0000_0004);
    apb(1'b0, 12'h004, 32'h0);
    chk("cur clear", rd, 32'h0);
    chk("volt clear", vlt, 11'h000);
    chk("locked", c3s, 1);
    rst <= 1'b1;
    adp <= 1'b0;
    cyc(5);
    rst <= 1'b0;
    cyc(4);
    chk("two cell", c3s, 0);
    hold <= 1'b1;
    lgt <= 1'b1;
    adp <= 1'b1;
    apb(1'b1, 12'h000, 32'h0000_0404);
    cyc(20);
    chk("pfm", pfm, 1);
    hsn = 0;
    cyc(1300);
    chk("audio", hsn >= 2, 1);
    apb(1'b1, 12'h000, 32'h0000_0004);
    cyc(20);
    hsn = 0;
    cyc(1300);
    chk("no audio", hsn, 0);
    complete_run();
  end
  initial begin
    cyc(20000);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
